// ---- verilog/fsas_pkg.sv ----
// Purpose: Shared constants for the fan speed alert status block
// Assumes: Four fans, 16-bit register data, byte addresses on 32-bit word steps
// Notes:   Speeds are in RPM, duty cycle in tenths of a percent
`default_nettype none
package fsas_pkg;
  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_FANS = 4;
  localparam int AW       = 8;
  localparam int DW       = 16;
  localparam int RPM_W    = 16;
  localparam int DUTY_W   = 10;
  localparam int IDX_W    = 2;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [AW-1:0] OFS_CTRL      = 8'h00;
  localparam logic [AW-1:0] OFS_ALERT_SRC = 8'h04;
  localparam logic [AW-1:0] OFS_CMD       = 8'h08;
  localparam logic [AW-1:0] OFS_MASK      = 8'h0C;
  localparam logic [AW-1:0] OFS_FAN_EN    = 8'h10;
  localparam logic [AW-1:0] OFS_SPD_FLAGS = 8'h14;
  localparam logic [AW-1:0] OFS_STL_FLAGS = 8'h18;
  localparam logic [AW-1:0] BASE_STALL    = 8'h20;
  localparam logic [AW-1:0] BASE_SPEED    = 8'h30;
  localparam logic [AW-1:0] BASE_TARGET   = 8'h40;
  localparam int            GRP_LSB       = 4;
  localparam int            IDX_LSB       = 2;

  // CTRL fields
  localparam int CTRL_ALERT_PIN = 0;
  localparam int CTRL_STALL_ALR = 1;
  localparam int CTRL_SPEED_ALR = 2;
  localparam int CTRL_TAKEOVER  = 3;
  localparam int CTRL_OPEN_LOOP = 4;
  localparam int CTRL_W         = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h06;

  // CMD fields
  localparam int CMD_CLR_STALL = 0;
  localparam int CMD_CLR_SPEED = 1;
  localparam int CMD_CLR_ALL   = 2;

  // Pending alert source codes
  localparam logic [1:0] SRC_STALL = 2'h1;
  localparam logic [1:0] SRC_SPEED = 2'h2;

  // Reset values
  localparam logic [NUM_FANS-1:0] MASK_RST   = 4'hF;
  localparam logic [NUM_FANS-1:0] FAN_EN_RST = 4'hF;
  localparam logic [RPM_W-1:0]    TARGET_RST = 16'h0000;

  // Thresholds
  localparam logic [RPM_W-1:0]  STALL_RPM = 16'h01CC;
  localparam logic [DUTY_W-1:0] DUTY_FULL = 10'h3E8;
  localparam logic [DUTY_W-1:0] DUTY_ZERO = 10'h000;
endpackage
`default_nettype wire

// ---- verilog/fsas_fan_chk.sv ----
// Purpose: Fault detection for one fan on each fresh speed measurement
// Assumes: meas_valid_i is a one-cycle pulse from the tachometer logic
// Notes:   Outputs are combinational one-cycle events
`timescale 1ns/100ps
`default_nettype none
module fsas_fan_chk
  import fsas_pkg::*;
(
  input  wire logic              meas_valid_i,
  input  wire logic [RPM_W-1:0]  meas_rpm_i,
  input  wire logic [DUTY_W-1:0] duty_i,
  input  wire logic [RPM_W-1:0]  target_rpm_i,
  input  wire logic              fan_en_i,
  input  wire logic              closed_loop_i,
  output logic                   stall_evt_o,
  output logic                   speed_evt_o
);
  logic sample;
  logic too_slow;
  logic too_fast;

  // Disabled fans take no part in measurement or regulation
  assign sample   = meas_valid_i & fan_en_i;
  assign too_slow = (target_rpm_i > meas_rpm_i) && (duty_i == DUTY_FULL);
  assign too_fast = (target_rpm_i < meas_rpm_i) && (duty_i == DUTY_ZERO);

  assign stall_evt_o = sample & (meas_rpm_i < STALL_RPM);
  assign speed_evt_o = sample & closed_loop_i & (too_slow | too_fast);
endmodule
`default_nettype wire

// ---- verilog/fsas_top.sv ----
// Purpose: Per-fan stall and regulation fault status with alert bookkeeping
// Assumes: Register port with read data one cycle after the read strobe
// Notes:   Reading a per-fan status clears that fan's flag only
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Fail flagged when too slow at full duty
// - Fail flagged when too fast at zero duty
// - Speed status read returns 0 ok, 1 fail
// - Speed status read clears only that fan
// - Clear-speed command clears all speed alerts
// - Clear-all command clears stall and speed alerts
// - Target speed of a fan is readable
// - Takeover select: 0 closed loop unless open loop is set, 1 host
// - Stall summary clears when all stalls cleared
// - Alert pin follows pending alerts when enabled
// - Disabled fans skip measurement and regulation
// - Stall set when speed below 460 RPM
// - Source bits: stall 0x01, speed 0x02
// - Per-fan alert mask, all enabled at reset
module fsas_top
  import fsas_pkg::*;
(
  input  wire logic                       mclk_i,
  input  wire logic                       sys_rst_i,
  input  wire logic [AW-1:0]              addr_i,
  input  wire logic [DW-1:0]              wdata_i,
  input  wire logic                       wr_i,
  input  wire logic                       rd_i,
  output logic      [DW-1:0]              rdata_o,
  input  wire logic [NUM_FANS-1:0]        meas_valid_i,
  input  wire logic [NUM_FANS*RPM_W-1:0]  meas_rpm_i,
  input  wire logic [NUM_FANS*DUTY_W-1:0] duty_i,
  output logic      [NUM_FANS*RPM_W-1:0]  target_rpm_o,
  output logic      [NUM_FANS-1:0]        meas_en_o,
  output logic      [NUM_FANS-1:0]        reg_en_o,
  output logic                            takeover_o,
  output logic                            alert_o
);
  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic in_group(input logic [AW-1:0] a, input logic [AW-1:0] base);
    in_group = (a[AW-1:GRP_LSB] == base[AW-1:GRP_LSB]);
  endfunction

  function automatic logic [IDX_W-1:0] fan_idx(input logic [AW-1:0] a);
    fan_idx = a[IDX_LSB+IDX_W-1:IDX_LSB];
  endfunction

  function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] base,
                               input int i);
    hit = in_group(a, base) && (fan_idx(a) == IDX_W'(i));
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [CTRL_W-1:0]   ctrl_q;
  logic [NUM_FANS-1:0] mask_q;
  logic [NUM_FANS-1:0] fan_en_q;
  logic [NUM_FANS-1:0] stall_q;
  logic [NUM_FANS-1:0] per_fan_regulation_flags_q;
  logic [RPM_W-1:0]    target_q [NUM_FANS];
  logic [DW-1:0]       rdata_q;
  logic                alert_q;

  logic [NUM_FANS-1:0] stall_evt;
  logic [NUM_FANS-1:0] speed_evt;
  logic [NUM_FANS-1:0] stall_clr;
  logic [NUM_FANS-1:0] speed_clr;
  logic                takeover_select;
  logic                closed_loop;
  logic [1:0]          alert_src;
  logic                cmd_wr;

  assign takeover_select = ctrl_q[CTRL_TAKEOVER];
  assign closed_loop     = ~ctrl_q[CTRL_OPEN_LOOP] & ~takeover_select;
  assign cmd_wr          = wr_i && (addr_i == OFS_CMD);

  // ---------------------------------------------------------------
  // Per-fan detection and clears
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NUM_FANS; i++) begin : g_fan
    fsas_fan_chk u_chk (
      .meas_valid_i  (meas_valid_i[i]),
      .meas_rpm_i    (meas_rpm_i[i*RPM_W +: RPM_W]),
      .duty_i        (duty_i[i*DUTY_W +: DUTY_W]),
      .target_rpm_i  (target_q[i]),
      .fan_en_i      (fan_en_q[i]),
      .closed_loop_i (closed_loop),
      .stall_evt_o   (stall_evt[i]),
      .speed_evt_o   (speed_evt[i])
    );

    assign stall_clr[i] = (rd_i && hit(addr_i, BASE_STALL, i))
                        | (cmd_wr && (wdata_i[CMD_CLR_STALL] || wdata_i[CMD_CLR_ALL]));
    assign speed_clr[i] = (rd_i && hit(addr_i, BASE_SPEED, i))
                        | (cmd_wr && (wdata_i[CMD_CLR_SPEED] || wdata_i[CMD_CLR_ALL]));

    assign target_rpm_o[i*RPM_W +: RPM_W] = target_q[i];
    assign meas_en_o[i] = fan_en_q[i];
    assign reg_en_o[i]  = fan_en_q[i] & closed_loop;

    always_ff @(posedge mclk_i or posedge sys_rst_i)
    begin
      if (sys_rst_i)
      begin
        target_q[i] <= TARGET_RST;
      end
      else if (wr_i && hit(addr_i, BASE_TARGET, i))
      begin
        target_q[i] <= wdata_i[RPM_W-1:0];
      end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge mclk_i or posedge sys_rst_i)
    begin
      if (sys_rst_i)
      begin
        stall_q[i]                    <= 1'b0;
        per_fan_regulation_flags_q[i] <= 1'b0;
      end
      else
      begin
        stall_q[i] <= stall_evt[i] | (stall_q[i] & ~stall_clr[i]);
        per_fan_regulation_flags_q[i] <= speed_evt[i]
                                       | (per_fan_regulation_flags_q[i] & ~speed_clr[i]);
      end
    end

    AST_SPEED_SLOW: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      (meas_valid_i[i] && fan_en_q[i] && closed_loop
       && target_q[i] > meas_rpm_i[i*RPM_W +: RPM_W]
       && duty_i[i*DUTY_W +: DUTY_W] == DUTY_FULL)
      |=> per_fan_regulation_flags_q[i])
      else $error("speed fail not flagged at full duty");

    AST_SPEED_FAST: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      (meas_valid_i[i] && fan_en_q[i] && closed_loop
       && target_q[i] < meas_rpm_i[i*RPM_W +: RPM_W]
       && duty_i[i*DUTY_W +: DUTY_W] == DUTY_ZERO)
      |=> per_fan_regulation_flags_q[i])
      else $error("speed fail not flagged at zero duty");

    AST_STALL_SET: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      (meas_valid_i[i] && fan_en_q[i] && meas_rpm_i[i*RPM_W +: RPM_W] < STALL_RPM)
      |=> stall_q[i])
      else $error("stall not flagged below threshold");

    AST_DISABLED_QUIET: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      (!fan_en_q[i] && !stall_q[i] && !per_fan_regulation_flags_q[i] && !stall_clr[i])
      |=> !stall_q[i] && !per_fan_regulation_flags_q[i])
      else $error("disabled fan raised a fault");

    AST_STICKY: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      (per_fan_regulation_flags_q[i] && !speed_clr[i]) |=> per_fan_regulation_flags_q[i])
      else $error("speed fault dropped without a clear");

    AST_TARGET_RD: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      (rd_i && hit(addr_i, BASE_TARGET, i)) |=> rdata_o == $past(target_q[i]))
      else $error("target readback mismatch");
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ctrl_q <= CTRL_RST;
    end
    else if (wr_i && addr_i == OFS_CTRL)
    begin
      ctrl_q <= wdata_i[CTRL_W-1:0];
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      mask_q   <= MASK_RST;
      fan_en_q <= FAN_EN_RST;
    end
    else if (wr_i)
    begin
      if (addr_i == OFS_MASK)
      begin
        mask_q <= wdata_i[NUM_FANS-1:0];
      end
      if (addr_i == OFS_FAN_EN)
      begin
        fan_en_q <= wdata_i[NUM_FANS-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Pending alert summary and pin
  // ---------------------------------------------------------------
  // Summaries are derived from the flags, so they drop as the last flag clears
  assign alert_src[0] = ctrl_q[CTRL_STALL_ALR] & |(stall_q & mask_q);
  assign alert_src[1] = ctrl_q[CTRL_SPEED_ALR] & ~ctrl_q[CTRL_OPEN_LOOP]
                      & |(per_fan_regulation_flags_q & mask_q);

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      alert_q <= 1'b0;
    end
    else
    begin
      alert_q <= ctrl_q[CTRL_ALERT_PIN] & |alert_src;
    end
  end

  assign alert_o    = alert_q;
  assign takeover_o = takeover_select;

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rdata_q <= '0;
    end
    else if (rd_i)
    begin
      rdata_q <= '0;
      if (in_group(addr_i, BASE_STALL))
      begin
        rdata_q <= DW'(stall_q[fan_idx(addr_i)]);
      end
      else if (in_group(addr_i, BASE_SPEED))
      begin
        rdata_q <= DW'(per_fan_regulation_flags_q[fan_idx(addr_i)]);
      end
      else if (in_group(addr_i, BASE_TARGET))
      begin
        rdata_q <= target_q[fan_idx(addr_i)];
      end
      else
      begin
        case (addr_i)
          OFS_CTRL:      rdata_q <= DW'(ctrl_q);
          OFS_ALERT_SRC: rdata_q <= DW'(alert_src);
          OFS_MASK:      rdata_q <= DW'(mask_q);
          OFS_FAN_EN:    rdata_q <= DW'(fan_en_q);
          OFS_SPD_FLAGS: rdata_q <= DW'(per_fan_regulation_flags_q);
          OFS_STL_FLAGS: rdata_q <= DW'(stall_q);
          default:       rdata_q <= '0;
        endcase
      end
    end
    else
    begin
      rdata_q <= '0;
    end
  end

  assign rdata_o = rdata_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_SPEED_RD: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (rd_i && in_group(addr_i, BASE_SPEED))
    |=> rdata_o == DW'($past(per_fan_regulation_flags_q[fan_idx(addr_i)])))
    else $error("speed status read wrong");

  AST_SPEED_RD_CLR: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (rd_i && in_group(addr_i, BASE_SPEED) && !cmd_wr)
    |=> ((per_fan_regulation_flags_q & ~$past(speed_evt))
         == ($past(per_fan_regulation_flags_q) & ~$past(speed_evt)
             & ~(NUM_FANS'(1) << $past(fan_idx(addr_i))))))
    else $error("speed read cleared the wrong fans");

  AST_CLR_SPEED: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (cmd_wr && wdata_i[CMD_CLR_SPEED] && speed_evt == '0)
    |=> per_fan_regulation_flags_q == '0 && !alert_src[1])
    else $error("clear speed left alerts");

  AST_CLR_ALL: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (cmd_wr && wdata_i[CMD_CLR_ALL] && speed_evt == '0 && stall_evt == '0)
    |=> stall_q == '0 && per_fan_regulation_flags_q == '0 && alert_src == 2'h0)
    else $error("clear all left alerts");

  AST_STALL_SUM: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (rd_i && in_group(addr_i, BASE_STALL) && stall_evt == '0
     && (stall_q & ~(NUM_FANS'(1) << fan_idx(addr_i))) == '0) |=> !alert_src[0])
    else $error("stall summary pending with no stalled fan");

  AST_TAKEOVER: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    takeover_o |-> reg_en_o == '0 && speed_evt == '0)
    else $error("regulator active under host takeover");

  AST_ALERT_PIN: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (ctrl_q[CTRL_ALERT_PIN] && alert_src != 2'h0) |=> alert_o)
    else $error("alert pin not raised");

  AST_MASK_GATE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (mask_q == '0) |-> alert_src == 2'h0)
    else $error("masked fans produced a pending alert");

  COV_STALL_READ: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    stall_q != '0 ##[1:20] (rd_i && in_group(addr_i, BASE_STALL)));
  COV_SPEED_FAIL: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    speed_evt != '0 ##1 alert_o);
  COV_CLR_ALL: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    cmd_wr && wdata_i[CMD_CLR_ALL] && stall_q != '0);
  COV_TAKEOVER: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    $rose(takeover_o));
endmodule
`default_nettype wire

// ---- test/fsas_host.sv ----
// Purpose: Host processor model driving the register port
// Assumes: Read data stand only in the cycle after the read strobe
// Notes:   Tasks are called from the testbench; strobes last one cycle
`timescale 1ns/100ps
`default_nettype none
module fsas_host
  import fsas_pkg::*;
(
  input  wire logic          mclk_i,
  input  wire logic [DW-1:0] rdata_i,
  output logic      [AW-1:0] addr_o,
  output logic      [DW-1:0] wdata_o,
  output logic               wr_o,
  output logic               rd_o
);
  initial
  begin
    addr_o  = '0;
    wdata_o = '0;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    logic [DW-1:0] v;
    v = d;
    // Takeover is never asked for under open-loop configuration
    if (a == OFS_CTRL && v[CTRL_OPEN_LOOP])
      v[CTRL_TAKEOVER] = 1'b0;
    @(posedge mclk_i);
    addr_o  <= a;
    wdata_o <= v;
    wr_o    <= 1'b1;
    @(posedge mclk_i);
    wr_o    <= 1'b0;
    // Return once the write has landed, so callers see settled outputs
    @(negedge mclk_i);
  endtask

  task automatic rd_reg(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge mclk_i);
    rd_o   <= 1'b0;
    @(negedge mclk_i);
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

// ---- test/fsas_top_tb.sv ----
// Purpose: Self-checking bench for the fan fault status block
// Assumes: Four fans, register port with one-cycle read latency
// Notes:   Each scenario task drives and judges on its own
`timescale 1ns/100ps
`default_nettype none
module fsas_top_tb
  import fsas_pkg::*;
;
  logic                       mclk_i;
  logic                       sys_rst_i;
  logic [AW-1:0]              addr;
  logic [DW-1:0]              wdata;
  logic                       wr;
  logic                       rd;
  logic [DW-1:0]              rdata;
  logic [NUM_FANS-1:0]        mv;
  logic [NUM_FANS*RPM_W-1:0]  rpm_v;
  logic [NUM_FANS*DUTY_W-1:0] duty_v;
  logic [NUM_FANS*RPM_W-1:0]  target;
  logic [NUM_FANS-1:0]        meas_en;
  logic [NUM_FANS-1:0]        reg_en;
  logic                       takeover;
  logic                       alert;
  int                         err_count;
  int                         num_checks;

  fsas_top i_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .meas_valid_i(mv), .meas_rpm_i(rpm_v),
    .duty_i(duty_v), .target_rpm_o(target), .meas_en_o(meas_en), .reg_en_o(reg_en),
    .takeover_o(takeover), .alert_o(alert));

  fsas_host i_host (.mclk_i(mclk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));

  initial
  begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rchk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    logic [DW-1:0] d;
    i_host.rd_reg(a, d);
    chk(d, exp, $sformatf("read %h", a));
  endtask

  task automatic meas(input int i, input logic [RPM_W-1:0] r, input logic [DUTY_W-1:0] d);
    @(posedge mclk_i);
    rpm_v[i*RPM_W +: RPM_W]    <= r;
    duty_v[i*DUTY_W +: DUTY_W] <= d;
    mv[i]                      <= 1'b1;
    @(posedge mclk_i);
    mv                         <= '0;
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk({15'h0000, alert}, 16'h0000, "alert");
    chk({15'h0000, takeover}, 16'h0000, "takeover");
    chk(target[15:0], TARGET_RST, "target");
    chk({12'h000, reg_en}, 16'h000F, "reg_en");
    rchk(OFS_CTRL, 16'h0006);
    rchk(OFS_MASK, 16'h000F);
    rchk(OFS_FAN_EN, 16'h000F);
    rchk(8'hFC, 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_stall();
    i_host.wr_reg(OFS_CTRL, 16'h0007);
    meas(1, 16'h01CB, 10'h1F4);
    meas(2, 16'h01CC, 10'h1F4);
    repeat (2) @(negedge mclk_i);
    chk({15'h0000, alert}, 16'h0001, "alert on");
    rchk(OFS_STL_FLAGS, 16'h0002);
    rchk(OFS_ALERT_SRC, 16'h0001);
    i_host.wr_reg(OFS_CTRL, 16'h0006);
    repeat (2) @(negedge mclk_i);
    chk({15'h0000, alert}, 16'h0000, "alert off");
    rchk(BASE_STALL + 8'h04, 16'h0001);
    rchk(BASE_STALL + 8'h04, 16'h0000);
    rchk(OFS_ALERT_SRC, 16'h0000);
    $display("test stall done");
  endtask

  task automatic t_speed();
    i_host.wr_reg(BASE_TARGET, 16'h0FA0);
    i_host.wr_reg(BASE_TARGET + 8'h08, 16'h0FA0);
    i_host.wr_reg(BASE_TARGET + 8'h0C, 16'h03E8);
    chk(target[15:0], 16'h0FA0, "target pin");
    rchk(BASE_TARGET + 8'h0C, 16'h03E8);
    meas(0, 16'h0BB8, DUTY_FULL);
    meas(3, 16'h07D0, DUTY_ZERO);
    meas(2, 16'h0BB8, 10'h3E7);
    rchk(OFS_SPD_FLAGS, 16'h0009);
    rchk(OFS_ALERT_SRC, 16'h0002);
    rchk(BASE_SPEED, 16'h0001);
    rchk(BASE_SPEED, 16'h0000);
    rchk(OFS_SPD_FLAGS, 16'h0008);
    rchk(BASE_SPEED + 8'h08, 16'h0000);
    i_host.wr_reg(OFS_CMD, 16'h0002);
    rchk(OFS_SPD_FLAGS, 16'h0000);
    rchk(OFS_ALERT_SRC, 16'h0000);
    $display("test speed done");
  endtask

  task automatic t_clear_all();
    meas(0, 16'h0064, 10'h1F4);
    meas(3, 16'h07D0, DUTY_ZERO);
    rchk(OFS_ALERT_SRC, 16'h0003);
    i_host.wr_reg(OFS_CMD, 16'h0004);
    rchk(OFS_STL_FLAGS, 16'h0000);
    rchk(OFS_SPD_FLAGS, 16'h0000);
    rchk(OFS_ALERT_SRC, 16'h0000);
    $display("test clear all done");
  endtask

  task automatic t_mask();
    i_host.wr_reg(OFS_MASK, 16'h000D);
    meas(1, 16'h0064, 10'h1F4);
    rchk(OFS_STL_FLAGS, 16'h0002);
    rchk(OFS_ALERT_SRC, 16'h0000);
    i_host.wr_reg(OFS_MASK, 16'h000F);
    rchk(OFS_ALERT_SRC, 16'h0001);
    i_host.wr_reg(OFS_CMD, 16'h0001);
    rchk(OFS_STL_FLAGS, 16'h0000);
    $display("test mask done");
  endtask

  task automatic t_disable();
    i_host.wr_reg(OFS_FAN_EN, 16'h000E);
    chk({12'h000, meas_en}, 16'h000E, "meas_en");
    chk({12'h000, reg_en}, 16'h000E, "reg_en");
    meas(0, 16'h0064, DUTY_FULL);
    rchk(OFS_STL_FLAGS, 16'h0000);
    rchk(OFS_SPD_FLAGS, 16'h0000);
    i_host.wr_reg(OFS_FAN_EN, 16'h000F);
    $display("test disable done");
  endtask

  task automatic t_takeover();
    i_host.wr_reg(OFS_CTRL, 16'h000E);
    chk({15'h0000, takeover}, 16'h0001, "takeover on");
    chk({12'h000, reg_en}, 16'h0000, "reg_en host");
    meas(0, 16'h0BB8, DUTY_FULL);
    rchk(OFS_SPD_FLAGS, 16'h0000);
    i_host.wr_reg(OFS_CTRL, 16'h001E);
    chk({15'h0000, takeover}, 16'h0000, "takeover open loop");
    chk({12'h000, reg_en}, 16'h0000, "reg_en open loop");
    meas(0, 16'h0BB8, DUTY_FULL);
    rchk(OFS_SPD_FLAGS, 16'h0000);
    i_host.wr_reg(OFS_CTRL, 16'h0006);
    chk({12'h000, reg_en}, 16'h000F, "reg_en closed");
    $display("test takeover done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    err_count  = 0;
    num_checks = 0;
    sys_rst_i  = 1'b1;
    mv         = '0;
    rpm_v      = '0;
    duty_v     = '0;
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(negedge mclk_i);
    t_reset();
    t_stall();
    t_speed();
    t_clear_all();
    t_mask();
    t_disable();
    t_takeover();
    wrap_up();
  end

  initial
  begin
    #20000;
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule
`default_nettype wire
